/* pkg/wdt_pkg.sv */
package wdt_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DIV_W = 5;
  localparam int unsigned EV_W = 4;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_KEY = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_CAUSE = 8'h10;
  localparam int unsigned ON_BIT = 15;
  localparam int unsigned RUN_DIV_LSB = 8;
  localparam int unsigned CLK_SEL_LSB = 6;
  localparam int unsigned SLP_DIV_LSB = 1;
  localparam int unsigned WIN_BIT = 0;
  localparam int unsigned CAUSE_TO_BIT = 0;
  localparam int unsigned EV_TIMEOUT = 0;
  localparam int unsigned EV_WAKE = 1;
  localparam int unsigned EV_WINDOW = 2;
  localparam int unsigned EV_BADKEY = 3;
  localparam logic [15:0] SERVICE_KEY = 16'h5743;
  localparam logic [1:0] CLK_SYS = 2'h0;
  localparam logic [1:0] CLK_RSVD = 2'h1;
  localparam logic [1:0] CLK_FRC = 2'h2;
  localparam logic [1:0] CLK_LOW_POWER_RC_OSC = 2'h3;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
  localparam logic [1:0] CFG_SETTLE = 2'h2;
  localparam logic [1:0] CFG_DONE = 2'h3;
  localparam int unsigned WINDOW_SHIFT = 2;
endpackage : wdt_pkg

/* pkg/wdt_if.sv */
`timescale 1ns/10ps
interface wdt_if;
  import wdt_pkg::*;
  logic sleep;
  logic [1:0] clk_sel;
  logic tick;
  logic en;
  logic clear;
  logic [DIV_W-1:0] div;
  logic expired;
  logic win_open;
  modport src (input sleep, input clk_sel, output tick);
  modport cnt (input tick, input en, input clear, input div, output expired, output win_open);
  modport ctl (output sleep, output clk_sel, output en, output clear, output div,
               input tick, input expired, input win_open);
endinterface : wdt_if

/* logic/clock_select_tick.sv */
`timescale 1ns/10ps
module clock_select_tick (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic low_power_rc_osc_osc_in,
  input wire logic frc_osc_in,
  wdt_if.src bus
);
  import wdt_pkg::*;
  typedef struct packed {
    logic [2:0] lp;
    logic [2:0] fr;
    logic tick;
  } sel_state_t;
  sel_state_t q, next_q;
  logic lp_rise, fr_rise;

  always_comb begin
    next_q = q;
    next_q.lp = {q.lp[1:0], low_power_rc_osc_osc_in};
    next_q.fr = {q.fr[1:0], frc_osc_in};
    lp_rise = q.lp[1] & ~q.lp[2];
    fr_rise = q.fr[1] & ~q.fr[2];
    if (bus.sleep) begin
      next_q.tick = lp_rise;
    end else begin
      unique case (bus.clk_sel)
        CLK_LOW_POWER_RC_OSC: next_q.tick = lp_rise;
        CLK_FRC: next_q.tick = fr_rise;
        CLK_SYS: next_q.tick = 1'b1;
        CLK_RSVD: next_q.tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) q <= '0;
    else q <= next_q;
  end

  assign bus.tick = q.tick;

  property p_sleep_low_power_rc_osc;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus.sleep && !lp_rise |=> !bus.tick;
  endproperty
  a_sleep_low_power_rc_osc: assert property (p_sleep_low_power_rc_osc) else $error("tick without low_power_rc_osc edge in sleep");
  property p_sys_tick;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !bus.sleep && bus.clk_sel == CLK_SYS |=> bus.tick;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("system clock source missed a tick");
endmodule : clock_select_tick

/* logic/postscale_counter.sv */
`timescale 1ns/10ps
module postscale_counter #(
  parameter int unsigned COUNT_W = 32
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  wdt_if.cnt bus
);
  import wdt_pkg::*;
  typedef struct packed {
    logic [COUNT_W-1:0] count;
  } cnt_state_t;
  cnt_state_t q, next_q;
  logic [COUNT_W:0] period;
  logic at_end;

  function automatic logic [COUNT_W:0] period_of(input logic [DIV_W-1:0] sel);
    period_of = (COUNT_W+1)'(1) << sel;
  endfunction : period_of

  always_comb begin
    next_q = q;
    period = period_of(bus.div);
    at_end = ({1'b0, q.count} == period - (COUNT_W+1)'(1));
    if (bus.clear || !bus.en) begin
      next_q.count = '0;
    end else if (bus.tick) begin
      next_q.count = at_end ? '0 : q.count + COUNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) q <= '0;
    else q <= next_q;
  end

  assign bus.expired = bus.en & bus.tick & at_end;
  // key is welcome only in the last quarter of the period, or at any time when the period is under 4
  assign bus.win_open = ({1'b0, q.count} >= period - (period >> WINDOW_SHIFT))
                        || (period < (COUNT_W+1)'(4));

  property p_wrap;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus.en && bus.tick && !bus.clear && at_end |=> q.count == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap at period end");
  property p_hold;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus.en && !bus.tick && !bus.clear |=> $stable(q.count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without a tick");
endmodule : postscale_counter

/* logic/dual_watchdog_timer.sv */
//
// Behaviour
// - run clock selectable, sleep uses low-power oscillator
// - missed service causes device reset
// - windowed and non-windowed modes supported
// - time-out in sleep wakes device
// - watchdog reset sets time-out flag
// - separate run and sleep periods
// - enable bit sets, clears software enable
// - enable bit reads one when enabled
// - run postscale divides by two to field
// - run clock select picks clock source
// - sleep postscale uses same encoding
// - postscale, clock fields read-only from straps
// - window bit forced by strap else software
// - window bit one enables window mode
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module dual_watchdog_timer (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [wdt_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sleep_mode_in,
  input wire logic low_power_rc_osc_osc_in,
  input wire logic frc_osc_in,
  input wire logic cfg_enable_in,
  input wire logic [wdt_pkg::DIV_W-1:0] cfg_run_div_in,
  input wire logic [1:0] cfg_run_clk_in,
  input wire logic [wdt_pkg::DIV_W-1:0] cfg_sleep_div_in,
  input wire logic cfg_window_in,
  output logic device_reset_out,
  output logic wake_out,
  output logic irq_out
);
  import wdt_pkg::*;

  localparam int unsigned CFG_W = 2 * DIV_W + 4;

  typedef struct packed {
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic [1:0] cap;
    logic cfg_en;
    logic [DIV_W-1:0] run_div;
    logic [1:0] run_clk;
    logic [DIV_W-1:0] slp_div;
    logic cfg_win;
    logic sw_on;
    logic sw_win;
    logic sleep_prev;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic to_flag;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic dev_rst;
    logic wake;
  } wdt_state_t;

  wdt_state_t q, next_q;
  logic ready, enabled, win_act;
  logic access, commit, mapped;
  logic key_good, key_write;
  logic svc_clear, win_fail, fail;
  logic [EV_W-1:0] ev;
  logic [31:0] rd_word;

  wdt_if bus ();

  clock_select_tick u_tick (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .low_power_rc_osc_osc_in(low_power_rc_osc_osc_in),
    .frc_osc_in(frc_osc_in),
    .bus(bus)
  );

  postscale_counter #(
    .COUNT_W(32)
  ) u_count (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .bus(bus)
  );

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFF_CTRL) || (a == OFF_KEY) || (a == OFF_STATUS)
                || (a == OFF_MASK) || (a == OFF_CAUSE);
  endfunction : is_mapped

  always_comb begin
    ready = (q.cap == CFG_DONE);
    enabled = ready & (q.cfg_en | q.sw_on);
    win_act = q.cfg_win | q.sw_win;
    access = psel_in & penable_in & ~q.pready;
    commit = psel_in & penable_in & q.pready;
    mapped = is_mapped(paddr_in);
    rd_word = '0;
    unique case (paddr_in)
      OFF_CTRL: begin
        rd_word[ON_BIT] = enabled;
        rd_word[RUN_DIV_LSB +: DIV_W] = q.run_div;
        rd_word[CLK_SEL_LSB +: 2] = q.run_clk;
        rd_word[SLP_DIV_LSB +: DIV_W] = q.slp_div;
        rd_word[WIN_BIT] = win_act;
      end
      OFF_STATUS: rd_word[EV_W-1:0] = q.status;
      OFF_MASK: rd_word[EV_W-1:0] = q.mask;
      OFF_CAUSE: rd_word[CAUSE_TO_BIT] = q.to_flag;
      default: rd_word = '0;
    endcase
    key_write = commit & pwrite_in & (paddr_in == OFF_KEY);
    key_good = key_write & (pstrb_in[1:0] == 2'b11)
               & (pwdata_in[15:0] == SERVICE_KEY);
    win_fail = key_good & enabled & win_act & ~bus.win_open;
    fail = win_fail | (bus.expired & ~sleep_mode_in);
    svc_clear = (key_good & enabled & ~win_fail) | win_fail
                | (sleep_mode_in != q.sleep_prev);
    ev = '0;
    ev[EV_TIMEOUT] = fail;
    ev[EV_WAKE] = bus.expired & sleep_mode_in;
    ev[EV_WINDOW] = win_fail;
    ev[EV_BADKEY] = key_write & ~key_good;
  end

  assign bus.sleep = sleep_mode_in;
  assign bus.clk_sel = q.run_clk;
  assign bus.en = enabled;
  assign bus.clear = svc_clear;
  assign bus.div = sleep_mode_in ? q.slp_div : q.run_div;

  always_comb begin
    next_q = q;
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;
    next_q.dev_rst = 1'b0;
    next_q.wake = 1'b0;
    next_q.sleep_prev = sleep_mode_in;
    // straps pass two flops, then are frozen once
    next_q.cfg_s1 = {cfg_enable_in, cfg_run_div_in, cfg_run_clk_in,
                     cfg_sleep_div_in, cfg_window_in};
    next_q.cfg_s2 = q.cfg_s1;
    if (q.cap != CFG_DONE) begin
      next_q.cap = q.cap + 2'h1;
    end
    if (q.cap == CFG_SETTLE) begin
      {next_q.cfg_en, next_q.run_div, next_q.run_clk,
       next_q.slp_div, next_q.cfg_win} = q.cfg_s2;
    end
    if (access) begin
      next_q.pready = 1'b1;
      next_q.pslverr = ~mapped;
      next_q.prdata = pwrite_in ? 32'h0000_0000 : rd_word;
    end
    if (commit && pwrite_in && mapped) begin
      unique case (paddr_in)
        OFF_CTRL: begin
          if (pstrb_in[1]) begin
            next_q.sw_on = pwdata_in[ON_BIT];
          end
          if (pstrb_in[0] && !q.cfg_win) begin
            next_q.sw_win = pwdata_in[WIN_BIT];
          end
        end
        OFF_MASK: begin
          if (pstrb_in[0]) begin
            next_q.mask = pwdata_in[EV_W-1:0];
          end
        end
        OFF_CAUSE: begin
          if (pstrb_in[0] && !pwdata_in[CAUSE_TO_BIT]) begin
            next_q.to_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (commit && !pwrite_in && paddr_in == OFF_STATUS) begin
      // clear only bits the read reported
      next_q.status = q.status & ~q.prdata[EV_W-1:0];
    end
    next_q.status = next_q.status | ev;
    if (fail) begin
      next_q.dev_rst = 1'b1;
      next_q.to_flag = 1'b1;
      next_q.sw_on = 1'b0;
      next_q.sw_win = 1'b0;
    end
    if (ev[EV_WAKE]) begin
      next_q.wake = 1'b1;
    end
    next_q.irq = |(next_q.status & next_q.mask);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.mask <= MASK_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign device_reset_out = q.dev_rst;
  assign wake_out = q.wake;
  assign irq_out = q.irq;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_read_ctrl;
    psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == OFF_CTRL;
  endsequence
  sequence s_good_key;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == OFF_KEY
      && pstrb_in[1:0] == 2'b11 && pwdata_in[15:0] == SERVICE_KEY;
  endsequence
  sequence s_commit_wr;
    psel_in && penable_in && pready_out && pwrite_in;
  endsequence

  property p_apb_ready;
    psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb answer not one wait state");
  property p_expire_reset;
    bus.expired && !sleep_mode_in |=> device_reset_out && q.to_flag && !wake_out;
  endproperty
  a_expire_reset: assert property (p_expire_reset) else $error("expiry gave no reset");
  property p_sleep_wake;
    bus.expired && sleep_mode_in |=> wake_out && !device_reset_out;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep expiry did not wake");
  property p_flag;
    device_reset_out |-> q.to_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("reset without time-out flag");
  property p_on_read;
    s_read_ctrl ##0 enabled |=> prdata_out[ON_BIT];
  endproperty
  a_on_read: assert property (p_on_read) else $error("enable bit read low while enabled");
  property p_win_cfg;
    s_read_ctrl ##0 q.cfg_win |=> prdata_out[WIN_BIT];
  endproperty
  a_win_cfg: assert property (p_win_cfg) else $error("strapped window bit read low");
  property p_bad_key;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == OFF_KEY
      && pwdata_in[15:0] != SERVICE_KEY && !bus.expired |=> !device_reset_out
      && q.status[EV_BADKEY];
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key not ignored");
  property p_early_key;
    s_good_key ##0 enabled && win_act && !bus.win_open |=> device_reset_out
      ##1 !device_reset_out;
  endproperty
  a_early_key: assert property (p_early_key) else $error("early key gave no reset");
  property p_sw_enable;
    s_commit_wr ##0 paddr_in == OFF_CTRL && pstrb_in[1] && pwdata_in[ON_BIT] && ready && !fail
      |=> enabled;
  endproperty
  a_sw_enable: assert property (p_sw_enable) else $error("software enable ignored");
  property p_irq;
    q.status[EV_TIMEOUT] && q.mask[EV_TIMEOUT] |-> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event without interrupt");
  property p_fields_ro;
    s_commit_wr ##0 paddr_in == OFF_CTRL && ready
      |=> $stable({q.run_div, q.run_clk, q.slp_div});
  endproperty
  a_fields_ro: assert property (p_fields_ro) else $error("read-only field changed");
  property p_cfg_on_kept;
    s_commit_wr ##0 paddr_in == OFF_CTRL && pstrb_in[1] && !pwdata_in[ON_BIT] && q.cfg_en
      && ready |=> enabled;
  endproperty
  a_cfg_on_kept: assert property (p_cfg_on_kept) else $error("strap enable cleared");
  property p_sw_off;
    s_commit_wr ##0 paddr_in == OFF_CTRL && pstrb_in[1] && !pwdata_in[ON_BIT] && !q.cfg_en
      |=> !enabled;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("software disable ignored");
  property p_win_sw;
    s_commit_wr ##0 paddr_in == OFF_CTRL && pstrb_in[0] && !q.cfg_win && ready && !fail
      |=> win_act == $past(pwdata_in[WIN_BIT]);
  endproperty
  a_win_sw: assert property (p_win_sw) else $error("window bit not under software");
  property p_win_locked;
    s_commit_wr ##0 paddr_in == OFF_CTRL && q.cfg_win && ready |=> win_act;
  endproperty
  a_win_locked: assert property (p_win_locked) else $error("strapped window bit cleared");
  property p_unmapped;
    psel_in && penable_in && !pready_out && !mapped |=> pslverr_out && prdata_out == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    psel_in && penable_in && !pready_out && mapped |=> !pslverr_out;
  endproperty
  a_mapped: assert property (p_mapped) else $error("error flagged on mapped access");
  property p_key_read;
    psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == OFF_KEY
      |=> prdata_out == '0;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key register read not zero");
  property p_sticky;
    !(commit && !pwrite_in && paddr_in == OFF_STATUS)
      |=> (q.status & $past(q.status)) == $past(q.status);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost without a read");
  property p_read_clear;
    commit && !pwrite_in && paddr_in == OFF_STATUS && ev == '0
      |=> (q.status & prdata_out[EV_W-1:0]) == '0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear");
  property p_bad_strobe;
    s_commit_wr ##0 paddr_in == OFF_KEY && pstrb_in[1:0] != 2'b11 && !bus.expired
      |=> !device_reset_out && q.status[EV_BADKEY];
  endproperty
  a_bad_strobe: assert property (p_bad_strobe) else $error("byte key write not ignored");
  property p_cause_clear;
    s_commit_wr ##0 paddr_in == OFF_CAUSE && pstrb_in[0] && !pwdata_in[CAUSE_TO_BIT] && !fail
      |=> !q.to_flag;
  endproperty
  a_cause_clear: assert property (p_cause_clear) else $error("time-out flag not cleared");
  property p_sleep_no_reset;
    sleep_mode_in && !win_fail |=> !device_reset_out;
  endproperty
  a_sleep_no_reset: assert property (p_sleep_no_reset) else $error("reset in sleep");
  property p_rsvd_clock;
    !sleep_mode_in && q.run_clk == CLK_RSVD |=> !bus.tick;
  endproperty
  a_rsvd_clock: assert property (p_rsvd_clock) else $error("reserved clock ticked");
  property p_irq_level;
    irq_out |-> (q.status & q.mask) != '0;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt without unmasked event");
endmodule : dual_watchdog_timer

/* tb/tb.sv */
`timescale 1ns/10ps
module tb;
  import wdt_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic sleep = 1'b0;
  logic low_power_rc_osc = 1'b0;
  logic fast_rc_osc = 1'b0;
  logic cfg_en = 1'b0;
  logic cfg_win = 1'b0;
  logic [4:0] cfg_rdiv = 5'h00;
  logic [4:0] cfg_sdiv = 5'h00;
  logic [1:0] cfg_clk = 2'h0;
  logic low_power_rc_osc_run = 1'b0;
  logic frc_run = 1'b0;
  logic [2:0] ocnt = 3'h0;
  logic [31:0] prdata;
  logic pready, pslverr, dev_rst, wake, irq, rd_e;
  logic [31:0] rd_v;
  int err_total = 0;
  int checks = 0;
  int rst_cnt = 0;
  int wake_cnt = 0;
  int n0, w0;

  dual_watchdog_timer dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .sleep_mode_in(sleep), .low_power_rc_osc_osc_in(low_power_rc_osc), .frc_osc_in(fast_rc_osc), .cfg_enable_in(cfg_en),
    .cfg_run_div_in(cfg_rdiv), .cfg_run_clk_in(cfg_clk), .cfg_sleep_div_in(cfg_sdiv),
    .cfg_window_in(cfg_win), .device_reset_out(dev_rst), .wake_out(wake), .irq_out(irq));

  always #5 ref_clk_in = ~ref_clk_in;

  // slow oscillators, held low while stopped
  always @(posedge ref_clk_in) begin
    ocnt <= ocnt + 3'h1;
    low_power_rc_osc <= low_power_rc_osc_run & ocnt[2];
    fast_rc_osc <= frc_run & ocnt[1];
    if (dev_rst === 1'b1) rst_cnt <= rst_cnt + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk_in);
    pen <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hF);
    chk(rd_v, exp);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : idle

  task automatic boot(input logic en, input logic [4:0] rdv, input logic [1:0] ck,
                      input logic [4:0] sdv, input logic win);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    cfg_en <= en;
    cfg_rdiv <= rdv;
    cfg_clk <= ck;
    cfg_sdiv <= sdv;
    cfg_win <= win;
    low_power_rc_osc_run <= 1'b0;
    frc_run <= 1'b0;
    sleep <= 1'b0;
    idle(20);
    rst_n_in <= 1'b1;
    idle(5);
  endtask : boot

  function automatic logic [31:0] f_ctrl(input logic en, input logic [4:0] rdv,
                                         input logic [1:0] ck, input logic [4:0] sdv,
                                         input logic win);
    return {16'h0000, en, 2'b00, rdv, ck, sdv, win};
  endfunction : f_ctrl

  initial begin
    boot(1'b0, 5'h03, CLK_SYS, 5'h02, 1'b0);
    rd(OFF_CTRL, f_ctrl(1'b0, 5'h03, CLK_SYS, 5'h02, 1'b0));
    wr(OFF_CTRL, 32'h0000_1FFF);
    rd(OFF_CTRL, f_ctrl(1'b0, 5'h03, CLK_SYS, 5'h02, 1'b1));
    wr(OFF_CTRL, 32'h0);
    idle(1);
    apb(1'b0, 8'h20, 32'h0, 4'hF);
    chk({31'h0, rd_e}, 32'h1);
    chk(rd_v, 32'h0);
    rd(OFF_KEY, 32'h0);
    $display("registers test done");
    // masked event keeps interrupt low
    n0 = rst_cnt;
    wr(OFF_CTRL, 32'h8000);
    idle(4);
    chk(rst_cnt - n0, 0);
    idle(36);
    chk(rst_cnt - n0, 1);
    chk({31'h0, irq}, 32'h0);
    rd(OFF_STATUS, 32'h1);
    wr(OFF_MASK, 32'h1);
    wr(OFF_CTRL, 32'h8000);
    idle(40);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_STATUS, 32'h1);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    rd(OFF_STATUS, 32'h0);
    rd(OFF_CAUSE, 32'h1);
    wr(OFF_CAUSE, 32'h0);
    rd(OFF_CAUSE, 32'h0);
    rd(OFF_CTRL, f_ctrl(1'b0, 5'h03, CLK_SYS, 5'h02, 1'b0));
    $display("timeout test done");
    boot(1'b0, 5'h05, CLK_SYS, 5'h00, 1'b0);
    wr(OFF_CTRL, 32'h8000);
    n0 = rst_cnt;
    repeat (10) begin
      wr(OFF_KEY, {16'h0000, SERVICE_KEY});
      idle(4);
    end
    chk(rst_cnt - n0, 0);
    wr(OFF_KEY, 32'h0000_5742);
    apb(1'b1, OFF_KEY, {16'h0000, SERVICE_KEY}, 4'h1);
    idle(40);
    chk(rst_cnt - n0, 1);
    rd(OFF_STATUS, 32'h9);
    $display("service test done");
    boot(1'b0, 5'h05, CLK_SYS, 5'h00, 1'b1);
    rd(OFF_CTRL, f_ctrl(1'b0, 5'h05, CLK_SYS, 5'h00, 1'b1));
    wr(OFF_CTRL, 32'h0);
    rd(OFF_CTRL, f_ctrl(1'b0, 5'h05, CLK_SYS, 5'h00, 1'b1));
    n0 = rst_cnt;
    wr(OFF_CTRL, 32'h8000);
    wr(OFF_KEY, {16'h0000, SERVICE_KEY});
    idle(6);
    chk(rst_cnt - n0, 1);
    apb(1'b0, OFF_STATUS, 32'h0, 4'hF);
    chk(rd_v & 32'h4, 32'h4);
    rd(OFF_CAUSE, 32'h1);
    wr(OFF_CTRL, 32'h8000);
    idle(22);
    wr(OFF_KEY, {16'h0000, SERVICE_KEY});
    n0 = rst_cnt;
    idle(12);
    chk(rst_cnt - n0, 0);
    $display("window test done");
    boot(1'b1, 5'h00, CLK_RSVD, 5'h02, 1'b0);
    rd(OFF_CTRL, f_ctrl(1'b1, 5'h00, CLK_RSVD, 5'h02, 1'b0));
    wr(OFF_CTRL, 32'h0);
    rd(OFF_CTRL, f_ctrl(1'b1, 5'h00, CLK_RSVD, 5'h02, 1'b0));
    n0 = rst_cnt;
    idle(50);
    chk(rst_cnt - n0, 0);
    sleep <= 1'b1;
    w0 = wake_cnt;
    idle(60);
    chk(wake_cnt - w0, 0);
    low_power_rc_osc_run <= 1'b1;
    idle(120);
    chk({31'h0, (wake_cnt - w0) > 1}, 32'h1);
    chk(rst_cnt - n0, 0);
    $display("sleep test done");
    for (int i = 2; i < 4; i++) begin
      boot(1'b1, 5'h01, i[1:0], 5'h00, 1'b0);
      n0 = rst_cnt;
      idle(40);
      chk(rst_cnt - n0, 0);
      if (i == 2) frc_run <= 1'b1;
      else low_power_rc_osc_run <= 1'b1;
      idle(60);
      chk({31'h0, (rst_cnt - n0) > 0}, 32'h1);
    end
    $display("clock source test done");
    end_of_test();
  end

  initial begin
    idle(20000);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : tb
